// ===== hdl/probe_map.svh
// Offsets, field positions, reset values and codes of the probe and flush block.
// Notes on behaviour
// - Probe fills 32-bit result register with status.
// - Result holds 20-bit physical page number.
// - Walk transfer error sets bus flag only.
// - Global flag copies final page global bit.
// - User attribute flags mirror page descriptor bits.
// - Supervisor flag copies descriptor, signals no violation.
// - Cache policy field copies descriptor mode bits.
// - Modified flag copies page modified bit.
// - Write-protect flag ORs all walked descriptors.
// - Transparent hit sets hit and resident only.
// - Resident means transparent hit or valid page.
// - Reset clears enables, keeps cache entries.
// - Register access never invalidates cache entries.
// - Flush-all invalidates every cache entry.
// - Selective flush invalidates matching address entry.
// - Local flush variants keep global entries.
// - Probe invalidates entry first, then reloads.
// - Destination code picks tree and cache.
// - Probe, flush, register moves need supervisor.
// - Legacy translation opcodes raise line-F trap.
// - Translation disabled passes addresses unchanged.
// - Transparent match overrides cached translation.
`ifndef PROBE_MAP_SVH
`define PROBE_MAP_SVH
// Control register selectors for register moves.
`define CREG_XCTL 4'h0
`define CREG_ITT0 4'h1
`define CREG_ITT1 4'h2
`define CREG_DTT0 4'h3
`define CREG_DTT1 4'h4
`define CREG_URP 4'h5
`define CREG_SRP 4'h6
`define CREG_RESULT 4'h7
`define CREG_DESTFC 4'h8
// Translation control fields and reset value.
`define XCTL_EN_BIT 15
`define XCTL_PAGE8K_BIT 14
`define XCTL_RESET 32'h0000_4000
`define TT_RESET 32'h0000_0000
`define RP_RESET 32'h0000_0000
`define DESTFC_RESET 3'h5
// Transparent window fields.
`define TT_BASE_MSB 31
`define TT_BASE_LSB 24
`define TT_MASK_MSB 23
`define TT_MASK_LSB 16
`define TT_EN_BIT 15
`define TT_SMODE_MSB 14
`define TT_SMODE_LSB 13
// Result register fields; this layout is fixed.
`define RES_PA_MSB 31
`define RES_PA_LSB 12
`define RES_BUS_BIT 11
`define RES_GLOB_BIT 10
`define RES_U1_BIT 9
`define RES_U0_BIT 8
`define RES_SUP_BIT 7
`define RES_CPOL_MSB 6
`define RES_CPOL_LSB 5
`define RES_MOD_BIT 4
`define RES_WP_BIT 2
`define RES_TT_BIT 1
`define RES_RES_BIT 0
`define RES_RESET 32'h0000_0000
// Descriptor fields.
`define DESC_GLOB_BIT 10
`define DESC_U1_BIT 9
`define DESC_U0_BIT 8
`define DESC_SUP_BIT 7
`define DESC_CPOL_MSB 6
`define DESC_CPOL_LSB 5
`define DESC_MOD_BIT 4
`define DESC_WP_BIT 2
`define DESC_TBL_VALID_BIT 1
// Translation cache size.
`define CACHE_ENTRIES 8
`define CACHE_IDX_W 3
`endif

// ===== hdl/probe_pkg.sv
// Types shared by the probe and flush block.
package probe_pkg;
	typedef enum logic [3:0] {
		OP_NONE = 4'h0,
		OP_CREG_WRITE = 4'h1,
		OP_CREG_READ = 4'h2,
		OP_PROBE = 4'h3,
		OP_PROBE_WRITE = 4'h4,
		OP_FLUSH = 4'h5,
		OP_FLUSH_LOCAL = 4'h6,
		OP_FLUSH_ALL = 4'h7,
		OP_FLUSH_ALL_LOCAL = 4'h8,
		OP_LEGACY = 4'h9
	} op_code_t;
	typedef enum logic [1:0] {
		INV_PROBE = 2'h0,
		INV_ADDR = 2'h1,
		INV_ALL = 2'h2
	} inv_kind_t;
	typedef enum logic [2:0] {
		WALK_IDLE = 3'b000,
		WALK_ROOT = 3'b001,
		WALK_PTR = 3'b011,
		WALK_PAGE = 3'b010
	} walk_state_t;
endpackage

// ===== hdl/window_match.sv
// Transparent window comparison for one memory unit.
`timescale 1ns/10ps
`include "probe_map.svh"
module window_match (
	input wire logic [31:0] win0,
	input wire logic [31:0] win1,
	input wire logic [7:0] addr_top,
	input wire logic sup_mode,
	output logic hit
);
	logic [31:0] win [2];
	logic [1:0] m;

	assign win[0] = win0;
	assign win[1] = win1;

	for (genvar i = 0; i < 2; i++) begin : g_win
		logic [7:0] diff;
		logic mode_ok;
		assign diff = (addr_top ^ win[i][`TT_BASE_MSB:`TT_BASE_LSB]) &
			~win[i][`TT_MASK_MSB:`TT_MASK_LSB];
		assign mode_ok = win[i][`TT_SMODE_MSB] |
			(win[i][`TT_SMODE_LSB] == sup_mode);
		assign m[i] = win[i][`TT_EN_BIT] & mode_ok & (diff == 8'h00);
	end

	assign hit = |m;
endmodule

// ===== hdl/translation_cache.sv
// Small fully associative translation cache with flush and reload.
`timescale 1ns/10ps
`include "probe_map.svh"
module translation_cache
	import probe_pkg::*;
(
	input wire logic clk,
	input wire logic [19:0] lk_tag,
	input wire logic lk_super,
	input wire logic lk_instr,
	output logic lk_hit,
	output logic [19:0] lk_page,
	input wire logic inv_req,
	input wire probe_pkg::inv_kind_t inv_kind,
	input wire logic inv_local,
	input wire logic [19:0] inv_tag,
	input wire logic inv_super,
	input wire logic inv_instr,
	input wire logic ld_req,
	input wire logic [19:0] ld_tag,
	input wire logic ld_super,
	input wire logic ld_instr,
	input wire logic ld_glob,
	input wire logic [19:0] ld_page
);
	// Entries are deliberately outside the reset: a processor reset
	// keeps cached translations, and software must flush them itself.
	logic valid_reg [`CACHE_ENTRIES];
	logic [19:0] tag_reg [`CACHE_ENTRIES];
	logic [19:0] page_reg [`CACHE_ENTRIES];
	logic super_reg [`CACHE_ENTRIES];
	logic instr_reg [`CACHE_ENTRIES];
	logic glob_reg [`CACHE_ENTRIES];
	logic [`CACHE_IDX_W-1:0] victim_reg;
	logic [`CACHE_IDX_W-1:0] victim_next;
	logic [`CACHE_ENTRIES-1:0] kill;
	logic [`CACHE_ENTRIES-1:0] hits;

	for (genvar i = 0; i < `CACHE_ENTRIES; i++) begin : g_ent
		logic sel;
		always_comb begin
			unique case (inv_kind)
				INV_ALL: sel = 1'b1;
				INV_ADDR: sel = (tag_reg[i] == inv_tag) &
					(super_reg[i] == inv_super);
				default: sel = (tag_reg[i] == inv_tag) &
					(super_reg[i] == inv_super) &
					(instr_reg[i] == inv_instr);
			endcase
		end
		// The valid bit stays out of the kill term: entries come up
		// unknown after power-up, and a flush must still clear them.
		assign kill[i] = inv_req & sel &
			~(inv_local & glob_reg[i]);
		assign hits[i] = valid_reg[i] & (tag_reg[i] == lk_tag) &
			(super_reg[i] == lk_super) & (instr_reg[i] == lk_instr);
		always_ff @(posedge clk) begin
			if (ld_req && victim_reg == `CACHE_IDX_W'(i)) begin
				valid_reg[i] <= 1'b1;
				tag_reg[i] <= ld_tag;
				page_reg[i] <= ld_page;
				super_reg[i] <= ld_super;
				instr_reg[i] <= ld_instr;
				glob_reg[i] <= ld_glob;
			end else if (kill[i]) begin
				valid_reg[i] <= 1'b0;
			end
		end
	end

	always_comb begin
		lk_hit = 1'b0;
		lk_page = 20'h00000;
		for (int j = 0; j < `CACHE_ENTRIES; j++) begin
			if (hits[j] && !lk_hit) begin
				lk_hit = 1'b1;
				lk_page = page_reg[j];
			end
		end
		victim_next = ld_req ? victim_reg + 1'b1 : victim_reg;
	end

	always_ff @(posedge clk) begin
		victim_reg <= victim_next;
	end
endmodule

// ===== hdl/translation_probe_and_flush.sv
// Translation registers, probe table walk, flushes and address lookup.
`timescale 1ns/10ps
`include "probe_map.svh"
module translation_probe_and_flush (
	input wire logic CORE_CLK,
	input wire logic SYS_RST,
	input wire logic OP_VALID,
	input wire probe_pkg::op_code_t OP_CODE,
	input wire logic OP_SUPER,
	input wire logic [3:0] OP_CREG,
	input wire logic [31:0] OP_ADDR,
	input wire logic [31:0] OP_WDATA,
	output logic OP_BUSY,
	output logic OP_DONE,
	output logic [31:0] OP_RDATA,
	output logic PRIV_FAULT,
	output logic LINEF_FAULT,
	output logic MEM_REQ,
	output logic [31:0] MEM_ADDR,
	input wire logic MEM_ACK,
	input wire logic MEM_ERR,
	input wire logic [31:0] MEM_RDATA,
	input wire logic [31:0] LOOKUP_ADDR,
	input wire logic LOOKUP_SUPER,
	input wire logic LOOKUP_INSTR,
	output logic [31:0] LOOKUP_PADDR,
	output logic LOOKUP_HIT,
	output logic [31:0] RESULT
);
	import probe_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	walk_state_t state_reg, state_next;
	logic [31:0] xctl_reg, xctl_next;
	logic [31:0] itt0_reg, itt0_next, itt1_reg, itt1_next;
	logic [31:0] dtt0_reg, dtt0_next, dtt1_reg, dtt1_next;
	logic [31:0] urp_reg, urp_next, srp_reg, srp_next;
	logic [31:0] result_reg, result_next;
	logic [2:0] destfc_reg, destfc_next;
	logic [31:0] la_reg, la_next;
	logic wacc_reg, wacc_next;
	logic busy_reg, busy_next, done_reg, done_next;
	logic [31:0] rdata_reg, rdata_next;
	logic priv_reg, priv_next, linef_reg, linef_next;
	logic req_reg, req_next;
	logic [31:0] maddr_reg, maddr_next;
	logic [31:0] lpaddr_reg, lpaddr_next;
	logic lhit_reg, lhit_next;

	logic destfc_super, destfc_instr, acc_w;
	logic probe_tt_hit, probe_ti, probe_td;
	logic look_ti, look_td, look_tt, look_hit;
	logic [19:0] look_page;
	logic inv_req, inv_local, ld_req;
	inv_kind_t inv_kind;
	logic [19:0] inv_tag;
	logic inv_super, inv_instr;

	// Function codes 2 and 6 are program fetches, FC2 selects the tree.
	assign destfc_super = destfc_reg[2];
	assign destfc_instr = (destfc_reg[1:0] == 2'b10);

	// ----------------------------------------------------------------
	// Transparent windows and translation cache
	// ----------------------------------------------------------------
	window_match u_probe_instr (
		.win0(itt0_reg),
		.win1(itt1_reg),
		.addr_top(OP_ADDR[31:24]),
		.sup_mode(destfc_super),
		.hit(probe_ti)
	);
	window_match u_probe_data (
		.win0(dtt0_reg),
		.win1(dtt1_reg),
		.addr_top(OP_ADDR[31:24]),
		.sup_mode(destfc_super),
		.hit(probe_td)
	);
	window_match u_look_instr (
		.win0(itt0_reg),
		.win1(itt1_reg),
		.addr_top(LOOKUP_ADDR[31:24]),
		.sup_mode(LOOKUP_SUPER),
		.hit(look_ti)
	);
	window_match u_look_data (
		.win0(dtt0_reg),
		.win1(dtt1_reg),
		.addr_top(LOOKUP_ADDR[31:24]),
		.sup_mode(LOOKUP_SUPER),
		.hit(look_td)
	);
	assign probe_tt_hit = destfc_instr ? probe_ti : probe_td;
	assign look_tt = LOOKUP_INSTR ? look_ti : look_td;

	translation_cache u_cache (
		.clk(CORE_CLK),
		.lk_tag(LOOKUP_ADDR[31:12]),
		.lk_super(LOOKUP_SUPER),
		.lk_instr(LOOKUP_INSTR),
		.lk_hit(look_hit),
		.lk_page(look_page),
		.inv_req(inv_req),
		.inv_kind(inv_kind),
		.inv_local(inv_local),
		.inv_tag(inv_tag),
		.inv_super(inv_super),
		.inv_instr(inv_instr),
		.ld_req(ld_req),
		.ld_tag(la_reg[31:12]),
		.ld_super(destfc_super),
		.ld_instr(destfc_instr),
		.ld_glob(MEM_RDATA[`DESC_GLOB_BIT]),
		.ld_page(MEM_RDATA[31:12])
	);

	// ----------------------------------------------------------------
	// Operation decode and table walk
	// ----------------------------------------------------------------
	// Register moves only store values; they never drive inv_req.
	always_comb begin
		state_next = state_reg;
		xctl_next = xctl_reg;
		itt0_next = itt0_reg;
		itt1_next = itt1_reg;
		dtt0_next = dtt0_reg;
		dtt1_next = dtt1_reg;
		urp_next = urp_reg;
		srp_next = srp_reg;
		result_next = result_reg;
		destfc_next = destfc_reg;
		la_next = la_reg;
		wacc_next = wacc_reg;
		done_next = 1'b0;
		rdata_next = rdata_reg;
		priv_next = 1'b0;
		linef_next = 1'b0;
		req_next = req_reg;
		maddr_next = maddr_reg;
		inv_req = 1'b0;
		inv_kind = INV_PROBE;
		inv_local = 1'b0;
		inv_tag = OP_ADDR[31:12];
		inv_super = destfc_super;
		inv_instr = destfc_instr;
		ld_req = 1'b0;
		acc_w = wacc_reg | MEM_RDATA[`DESC_WP_BIT];
		unique case (state_reg)
			WALK_IDLE: begin
				if (OP_VALID && OP_CODE == OP_LEGACY) begin
					linef_next = 1'b1;
					done_next = 1'b1;
				end else if (OP_VALID && OP_CODE != OP_NONE &&
						!OP_SUPER) begin
					priv_next = 1'b1;
					done_next = 1'b1;
				end else if (OP_VALID) begin
					case (OP_CODE)
						OP_CREG_WRITE: begin
							done_next = 1'b1;
							case (OP_CREG)
								`CREG_XCTL: xctl_next = OP_WDATA;
								`CREG_ITT0: itt0_next = OP_WDATA;
								`CREG_ITT1: itt1_next = OP_WDATA;
								`CREG_DTT0: dtt0_next = OP_WDATA;
								`CREG_DTT1: dtt1_next = OP_WDATA;
								`CREG_URP: urp_next = OP_WDATA;
								`CREG_SRP: srp_next = OP_WDATA;
								`CREG_RESULT: result_next = OP_WDATA;
								`CREG_DESTFC: destfc_next = OP_WDATA[2:0];
								default: ;
							endcase
						end
						OP_CREG_READ: begin
							done_next = 1'b1;
							case (OP_CREG)
								`CREG_XCTL: rdata_next = xctl_reg;
								`CREG_ITT0: rdata_next = itt0_reg;
								`CREG_ITT1: rdata_next = itt1_reg;
								`CREG_DTT0: rdata_next = dtt0_reg;
								`CREG_DTT1: rdata_next = dtt1_reg;
								`CREG_URP: rdata_next = urp_reg;
								`CREG_SRP: rdata_next = srp_reg;
								`CREG_RESULT: rdata_next = result_reg;
								`CREG_DESTFC: rdata_next = {29'h0, destfc_reg};
								default: rdata_next = 32'h0000_0000;
							endcase
						end
						OP_PROBE, OP_PROBE_WRITE: begin
							inv_req = 1'b1;
							la_next = OP_ADDR;
							if (probe_tt_hit) begin
								result_next = `RES_RESET;
								result_next[`RES_TT_BIT] = 1'b1;
								result_next[`RES_RES_BIT] = 1'b1;
								done_next = 1'b1;
							end else begin
								wacc_next = 1'b0;
								req_next = 1'b1;
								maddr_next = {(destfc_super ? srp_reg[31:9] :
									urp_reg[31:9]), OP_ADDR[31:25],
									2'b00};
								state_next = WALK_ROOT;
							end
						end
						OP_FLUSH, OP_FLUSH_LOCAL: begin
							inv_req = 1'b1;
							inv_kind = INV_ADDR;
							inv_local = (OP_CODE == OP_FLUSH_LOCAL);
							done_next = 1'b1;
						end
						OP_FLUSH_ALL, OP_FLUSH_ALL_LOCAL: begin
							inv_req = 1'b1;
							inv_kind = INV_ALL;
							inv_local = (OP_CODE == OP_FLUSH_ALL_LOCAL);
							done_next = 1'b1;
						end
						default: ;
					endcase
				end
			end
			WALK_ROOT, WALK_PTR: begin
				if (MEM_ACK) begin
					wacc_next = acc_w;
					if (MEM_ERR) begin
						result_next = `RES_RESET;
						result_next[`RES_BUS_BIT] = 1'b1;
					end else if (!MEM_RDATA[`DESC_TBL_VALID_BIT]) begin
						result_next = `RES_RESET;
						result_next[`RES_WP_BIT] = acc_w;
					end else if (state_reg == WALK_ROOT) begin
						maddr_next = {MEM_RDATA[31:9], la_reg[24:18], 2'b00};
						state_next = WALK_PTR;
					end else begin
						maddr_next = {MEM_RDATA[31:8], la_reg[17:12], 2'b00};
						state_next = WALK_PAGE;
					end
					if (MEM_ERR || !MEM_RDATA[`DESC_TBL_VALID_BIT]) begin
						req_next = 1'b0;
						done_next = 1'b1;
						state_next = WALK_IDLE;
					end
				end
			end
			WALK_PAGE: begin
				if (MEM_ACK) begin
					req_next = 1'b0;
					done_next = 1'b1;
					state_next = WALK_IDLE;
					result_next = `RES_RESET;
					if (MEM_ERR) begin
						result_next[`RES_BUS_BIT] = 1'b1;
					end else begin
						result_next[`RES_PA_MSB:`RES_PA_LSB] =
							MEM_RDATA[31:12];
						result_next[`RES_GLOB_BIT] =
							MEM_RDATA[`DESC_GLOB_BIT];
						result_next[`RES_U1_BIT] = MEM_RDATA[`DESC_U1_BIT];
						result_next[`RES_U0_BIT] = MEM_RDATA[`DESC_U0_BIT];
						result_next[`RES_SUP_BIT] =
							MEM_RDATA[`DESC_SUP_BIT];
						result_next[`RES_CPOL_MSB:`RES_CPOL_LSB] =
							MEM_RDATA[`DESC_CPOL_MSB:`DESC_CPOL_LSB];
						result_next[`RES_MOD_BIT] =
							MEM_RDATA[`DESC_MOD_BIT];
						result_next[`RES_WP_BIT] = acc_w;
						result_next[`RES_RES_BIT] =
							(MEM_RDATA[1:0] != 2'b00);
						ld_req = (MEM_RDATA[1:0] != 2'b00);
					end
				end
			end
			default: state_next = WALK_IDLE;
		endcase
		busy_next = (state_next != WALK_IDLE);
		// Transparent windows win over the cache and work even while
		// paged translation is off.
		if (look_tt || !xctl_reg[`XCTL_EN_BIT]) begin
			lpaddr_next = LOOKUP_ADDR;
			lhit_next = 1'b1;
		end else begin
			lpaddr_next = {look_page, LOOKUP_ADDR[11:0]};
			lhit_next = look_hit;
		end
	end

	// Reset clears the enable bits and the result and loads destfc_reg with 5; root pointers and window bases
	// keep their value so a warm restart can re-enable them.
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			state_reg <= WALK_IDLE;
			xctl_reg <= xctl_reg & ~(32'h1 << `XCTL_EN_BIT);
			itt0_reg <= itt0_reg & ~(32'h1 << `TT_EN_BIT);
			itt1_reg <= itt1_reg & ~(32'h1 << `TT_EN_BIT);
			dtt0_reg <= dtt0_reg & ~(32'h1 << `TT_EN_BIT);
			dtt1_reg <= dtt1_reg & ~(32'h1 << `TT_EN_BIT);
			destfc_reg <= `DESTFC_RESET;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			priv_reg <= 1'b0;
			linef_reg <= 1'b0;
			req_reg <= 1'b0;
			maddr_reg <= 32'h0000_0000;
			lpaddr_reg <= 32'h0000_0000;
			lhit_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			xctl_reg <= xctl_next;
			itt0_reg <= itt0_next;
			itt1_reg <= itt1_next;
			dtt0_reg <= dtt0_next;
			dtt1_reg <= dtt1_next;
			destfc_reg <= destfc_next;
			busy_reg <= busy_next;
			done_reg <= done_next;
			rdata_reg <= rdata_next;
			priv_reg <= priv_next;
			linef_reg <= linef_next;
			req_reg <= req_next;
			maddr_reg <= maddr_next;
			lpaddr_reg <= lpaddr_next;
			lhit_reg <= lhit_next;
		end
		urp_reg <= SYS_RST ? urp_reg : urp_next;
		srp_reg <= SYS_RST ? srp_reg : srp_next;
		result_reg <= SYS_RST ? `RES_RESET : result_next;
		la_reg <= la_next;
		wacc_reg <= wacc_next;
	end

	assign OP_BUSY = busy_reg;
	assign OP_DONE = done_reg;
	assign OP_RDATA = rdata_reg;
	assign PRIV_FAULT = priv_reg;
	assign LINEF_FAULT = linef_reg;
	assign MEM_REQ = req_reg;
	assign MEM_ADDR = maddr_reg;
	assign LOOKUP_PADDR = lpaddr_reg;
	assign LOOKUP_HIT = lhit_reg;
	assign RESULT = result_reg;
endmodule

// ===== verification/desc_memory.sv
// Descriptor memory model that answers table walk reads.
`timescale 1ns/10ps
module desc_memory (
	input wire logic clk,
	input wire logic req,
	input wire logic [31:0] tbl_desc,
	input wire logic [31:0] page_desc,
	input wire logic fail,
	input wire logic slow,
	output logic ack,
	output logic err,
	output logic [31:0] rdata
);
	// ----
	// Read responder
	// ----
	// Outside an answer the data and error lines flip every cycle, so a
	// walker that samples them without an acknowledge sees garbage.
	logic [1:0] level = 2'h0;
	logic [1:0] wait_cnt = 2'h0;
	initial begin
		ack = 1'b0;
		err = 1'b0;
		rdata = 32'h0;
	end
	always @(posedge clk) begin
		if (req && !ack && wait_cnt == {slow, slow}) begin
			ack <= 1'b1;
			err <= fail;
			rdata <= (level == 2'h2) ? page_desc : tbl_desc;
			level <= level + 2'h1;
		end else begin
			ack <= 1'b0;
			err <= ~err;
			rdata <= ~rdata;
			level <= req ? level : 2'h0;
		end
		wait_cnt <= (req && !ack && wait_cnt != {slow, slow}) ?
			wait_cnt + 2'h1 : 2'h0;
	end
endmodule

// ===== verification/translation_probe_and_flush_properties.sv
// Concurrent checks on the ports of the probe and flush block.
`timescale 1ns/10ps
module probe_checker
	import probe_pkg::*;
(
	input wire logic CORE_CLK,
	input wire logic SYS_RST,
	input wire logic OP_VALID,
	input wire probe_pkg::op_code_t OP_CODE,
	input wire logic OP_SUPER,
	input wire logic [31:0] OP_ADDR,
	input wire logic OP_BUSY,
	input wire logic OP_DONE,
	input wire logic PRIV_FAULT,
	input wire logic LINEF_FAULT,
	input wire logic MEM_REQ,
	input wire logic [31:0] MEM_ADDR,
	input wire logic MEM_ACK,
	input wire logic MEM_ERR,
	input wire logic [31:0] MEM_RDATA,
	input wire logic [31:0] RESULT
);
	// ----
	// Walk and fault properties
	// ----
	// Acks are counted per walk, since the page level is not visible.
	logic [1:0] acks_reg;
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST || !MEM_REQ)
			acks_reg <= 2'h0;
		else if (MEM_ACK)
			acks_reg <= acks_reg + 2'h1;
	end
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (SYS_RST);
	sequence op_taken;
		OP_VALID && !OP_BUSY;
	endsequence
	sequence page_ack;
		MEM_REQ && MEM_ACK && !MEM_ERR && acks_reg == 2'h2;
	endsequence
	priv_fault_a: assert property (
		op_taken ##0 (!OP_SUPER && OP_CODE != OP_NONE &&
		OP_CODE != OP_LEGACY) |=> OP_DONE && PRIV_FAULT)
		else $error("user level op not faulted");
	legacy_trap_a: assert property (
		op_taken ##0 OP_CODE == OP_LEGACY |=> OP_DONE && LINEF_FAULT
		&& !PRIV_FAULT) else $error("legacy opcode not trapped");
	req_hold_a: assert property (
		MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR))
		else $error("descriptor read dropped or moved");
	bus_err_a: assert property (
		MEM_REQ && MEM_ACK && MEM_ERR |=> OP_DONE && !MEM_REQ &&
		RESULT == 32'h0000_0800) else $error("bad bus error result");
	tt_only_a: assert property (
		RESULT[1] |-> RESULT == 32'h0000_0003)
		else $error("window hit result has extra bits");
	page_fields_a: assert property (
		page_ack ##0 MEM_RDATA[1:0] != 2'h0 |=> OP_DONE &&
		RESULT[31:12] == $past(MEM_RDATA[31:12]) &&
		RESULT[10:4] == $past(MEM_RDATA[10:4]))
		else $error("page fields not copied");
	resident_a: assert property (
		page_ack |=> RESULT[0] == ($past(MEM_RDATA[1:0]) != 2'h0))
		else $error("resident flag wrong");
	write_prot_a: assert property (
		page_ack ##0 MEM_RDATA[2] |=> RESULT[2])
		else $error("page write protect lost");
	root_index_a: assert property (
		$rose(MEM_REQ) |-> MEM_ADDR[8:0] == {$past(OP_ADDR[31:25]),
		2'b00}) else $error("root index wrong");
endmodule
bind translation_probe_and_flush probe_checker u_checker (
	.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .OP_VALID(OP_VALID),
	.OP_CODE(OP_CODE), .OP_SUPER(OP_SUPER), .OP_ADDR(OP_ADDR),
	.OP_BUSY(OP_BUSY), .OP_DONE(OP_DONE), .PRIV_FAULT(PRIV_FAULT),
	.LINEF_FAULT(LINEF_FAULT), .MEM_REQ(MEM_REQ), .MEM_ADDR(MEM_ADDR),
	.MEM_ACK(MEM_ACK), .MEM_ERR(MEM_ERR), .MEM_RDATA(MEM_RDATA),
	.RESULT(RESULT)
);

// ===== verification/tb_translation_probe_and_flush.sv
// Self-checking bench for the probe and flush block.
`timescale 1ns/10ps
module tb_translation_probe_and_flush;
	import probe_pkg::*;
	// ----
	// Stimulus and wiring
	// ----
	typedef struct {
		logic [2:0] fcode;
		logic [31:0] tbl;
		logic [31:0] page;
		logic [31:0] exp;
	} row_t;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic op_valid = 1'b0;
	op_code_t op_code = OP_NONE;
	logic op_super = 1'b1;
	logic [3:0] op_creg = 4'h0;
	logic [31:0] op_addr = 32'h0;
	logic [31:0] op_wdata = 32'h0;
	logic [31:0] lk_addr = 32'h0;
	logic [31:0] tbl_desc = 32'h0;
	logic [31:0] page_desc = 32'h0;
	logic fail = 1'b0;
	logic slow = 1'b0;
	logic lk_super = 1'b1;
	logic lk_instr = 1'b0;
	logic bsy;
	logic op_busy, op_done, priv_fault, linef_fault;
	logic mem_req, mem_ack, mem_err, lk_hit, req_d;
	logic [31:0] op_rdata, mem_addr, mem_rdata, lk_paddr, result;
	logic [31:0] root_addr;
	logic [1:0] flt;
	int miscompares = 0;
	int checked = 0;
	int cycles = 0;
	row_t rows [6] = '{
		'{3'h5, 32'h0000_2002, 32'h1234_5401, 32'h1234_5401},
		'{3'h1, 32'h0000_2002, 32'hab00_0391, 32'hab00_0391},
		'{3'h5, 32'h0000_2002, 32'h0000_0061, 32'h0000_0061},
		'{3'h5, 32'h0000_2006, 32'h0000_5001, 32'h0000_5005},
		'{3'h5, 32'h0000_2002, 32'h0000_5000, 32'h0000_5000},
		'{3'h1, 32'h0000_2000, 32'h0000_5001, 32'h0000_0000}
	};
	always #4 clk = ~clk;
	translation_probe_and_flush u_dut (
		.CORE_CLK(clk), .SYS_RST(rst), .OP_VALID(op_valid),
		.OP_CODE(op_code), .OP_SUPER(op_super), .OP_CREG(op_creg),
		.OP_ADDR(op_addr), .OP_WDATA(op_wdata), .OP_BUSY(op_busy),
		.OP_DONE(op_done), .OP_RDATA(op_rdata), .PRIV_FAULT(priv_fault),
		.LINEF_FAULT(linef_fault), .MEM_REQ(mem_req),
		.MEM_ADDR(mem_addr), .MEM_ACK(mem_ack), .MEM_ERR(mem_err),
		.MEM_RDATA(mem_rdata), .LOOKUP_ADDR(lk_addr),
		.LOOKUP_SUPER(lk_super), .LOOKUP_INSTR(lk_instr),
		.LOOKUP_PADDR(lk_paddr), .LOOKUP_HIT(lk_hit), .RESULT(result)
	);
	desc_memory u_mem (
		.clk(clk), .req(mem_req), .tbl_desc(tbl_desc),
		.page_desc(page_desc), .fail(fail), .slow(slow),
		.ack(mem_ack), .err(mem_err), .rdata(mem_rdata)
	);
	// The first address of each walk is kept to see which tree was used.
	always @(posedge clk) begin
		req_d <= mem_req;
		if (mem_req && !req_d)
			root_addr <= mem_addr;
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares = miscompares + 1;
			test_done();
		end
	end
	// ----
	// Tasks
	// ----
	task automatic test_done();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checked = checked + 1;
		if (got !== exp) begin
			miscompares = miscompares + 1;
			$display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic op(input op_code_t code, input logic [3:0] creg,
		input logic [31:0] val, input logic sup);
		int n;
		@(negedge clk);
		op_valid = 1'b1;
		op_code = code;
		op_creg = creg;
		op_addr = val;
		op_wdata = val;
		op_super = sup;
		@(posedge clk);
		@(negedge clk);
		op_valid = 1'b0;
		bsy = op_busy;
		for (n = 0; n < 100 && op_done !== 1'b1; n++)
			@(negedge clk);
		flt = {priv_fault, linef_fault};
	endtask
	task automatic look(input logic [31:0] a, input logic hit,
		input logic [31:0] pa);
		@(negedge clk);
		lk_addr = a;
		@(posedge clk);
		@(negedge clk);
		check({31'h0, lk_hit}, {31'h0, hit});
		if (hit)
			check(lk_paddr, pa);
	endtask
	// ----
	// Main sequence
	// ----
	initial begin
		int i;
		repeat (8) @(negedge clk);
		rst = 1'b0;
		check(result, 32'h0);
		look(32'h1234_5678, 1'b1, 32'h1234_5678);
		op(OP_CREG_WRITE, 4'h6, 32'h0000_1000, 1'b1);
		op(OP_CREG_WRITE, 4'h5, 32'h0000_3000, 1'b1);
		op(OP_CREG_WRITE, 4'h0, 32'h0000_8000, 1'b1);
		op(OP_FLUSH_ALL, 4'h0, 32'h0, 1'b1);
		for (i = 0; i < 6; i++) begin
			tbl_desc = rows[i].tbl;
			page_desc = rows[i].page;
			slow = i[0];
			op(OP_CREG_WRITE, 4'h8, {29'h0, rows[i].fcode}, 1'b1);
			op(i[0] ? OP_PROBE : OP_PROBE_WRITE, 4'h0, 32'h0840_3000, 1'b1);
			check(result, rows[i].exp);
			check({31'h0, bsy}, 32'h1);
			check({31'h0, op_busy}, 32'h0);
			check(root_addr, rows[i].fcode[2] ? 32'h1010 : 32'h3010);
		end
		$display("probe rows done");
		op(OP_CREG_WRITE, 4'h8, 32'h5, 1'b1);
		tbl_desc = 32'h0000_2002;
		page_desc = 32'h7777_7401;
		op(OP_PROBE, 4'h0, 32'h0840_3000, 1'b1);
		look(32'h0840_3abc, 1'b1, 32'h7777_7abc);
		lk_instr = 1'b1;
		look(32'h0840_3abc, 1'b0, 32'h0);
		lk_instr = 1'b0;
		lk_super = 1'b0;
		look(32'h0840_3abc, 1'b0, 32'h0);
		lk_super = 1'b1;
		op(OP_CREG_WRITE, 4'h0, 32'h0000_8000, 1'b1);
		look(32'h0840_3abc, 1'b1, 32'h7777_7abc);
		op(OP_FLUSH_ALL, 4'h0, 32'h0, 1'b0);
		check({30'h0, flt}, 32'h2);
		op(OP_FLUSH_LOCAL, 4'h0, 32'h0840_3000, 1'b1);
		op(OP_FLUSH_ALL_LOCAL, 4'h0, 32'h0, 1'b1);
		look(32'h0840_3abc, 1'b1, 32'h7777_7abc);
		op(OP_FLUSH, 4'h0, 32'h0840_3000, 1'b1);
		look(32'h0840_3abc, 1'b0, 32'h0);
		page_desc = 32'h7777_7001;
		op(OP_PROBE, 4'h0, 32'h0840_3000, 1'b1);
		op(OP_FLUSH_ALL_LOCAL, 4'h0, 32'h0, 1'b1);
		look(32'h0840_3abc, 1'b0, 32'h0);
		page_desc = 32'h7777_7401;
		op(OP_PROBE, 4'h0, 32'h0840_3000, 1'b1);
		rst = 1'b1;
		@(negedge clk);
		rst = 1'b0;
		look(32'h0840_3abc, 1'b1, 32'h0840_3abc);
		op(OP_CREG_WRITE, 4'h0, 32'h0000_8000, 1'b1);
		look(32'h0840_3abc, 1'b1, 32'h7777_7abc);
		op(OP_FLUSH_ALL, 4'h0, 32'h0, 1'b1);
		look(32'h0840_3abc, 1'b0, 32'h0);
		$display("cache flush tests done");
		op(OP_PROBE, 4'h0, 32'h0840_3000, 1'b1);
		op(OP_CREG_WRITE, 4'h3, 32'h0800_c000, 1'b1);
		look(32'h0840_3abc, 1'b1, 32'h0840_3abc);
		op(OP_PROBE, 4'h0, 32'h0840_3000, 1'b1);
		check(result, 32'h0000_0003);
		op(OP_CREG_WRITE, 4'h3, 32'h0, 1'b1);
		fail = 1'b1;
		op(OP_PROBE, 4'h0, 32'h0840_3000, 1'b1);
		check(result, 32'h0000_0800);
		fail = 1'b0;
		op(OP_CREG_READ, 4'h7, 32'h0, 1'b1);
		check(op_rdata, 32'h0000_0800);
		op(OP_LEGACY, 4'h0, 32'h0, 1'b0);
		check({30'h0, flt}, 32'h1);
		op(OP_LEGACY, 4'h0, 32'h0, 1'b1);
		check({30'h0, flt}, 32'h1);
		$display("window and fault tests done");
		test_done();
	end
endmodule
